// ==== rtl/cmc_pkg.sv ====
/*
  package for the configurable logic cell: register map, field layouts,
  selector encodings and bus widths.
  assumes an APB master with 32-bit data and one aligned word per register.
*/
package cmc_pkg;

    // bus and cell sizes
    localparam int GLOBAL_W   = 40;
    localparam int REGION_W   = 4;
    localparam int PT_IN_W    = GLOBAL_W + REGION_W;
    localparam int NUM_PT     = 5;
    localparam int NUM_GCLK   = 3;
    localparam int OE_IO_W    = 4;
    localparam int OE_CELL_W  = 4;
    localparam int ADDR_W     = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_PT_BASE  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_SIGN     = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_PROTECT  = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h5C;
    localparam logic [ADDR_W-1:0] ADDR_PT_LAST  = 8'h4C;

    // product-term registers: two words per term (true mask, complement mask)
    localparam int PT_WORD_SHIFT = 3;

    // reset values
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [15:0] SIGN_RESET   = 16'h0000;
    localparam logic [31:0] PT_MASK_OFF  = 32'hFFFF_FFFF;

    // selector encodings
    typedef enum logic [1:0] {XOR_LOW, XOR_HIGH, XOR_PT} cmc_xor_sel_t;
    typedef enum logic [1:0] {D_XOR, D_PT, D_PIN} cmc_dsel_t;
    typedef enum logic [1:0] {CLR_NONE, CLR_GLOBAL, CLR_PT, CLR_BOTH} cmc_clr_sel_t;
    typedef enum logic [2:0] {OE_PIN0, OE_PIN1, OE_IO, OE_CELL, OE_ON} cmc_oe_sel_t;

    // config register layout
    typedef struct packed {
        logic [3:0]   spare;
        logic [1:0]   oeCellIdx;
        logic [1:0]   oeIoIdx;
        logic         oeInvert;
        cmc_oe_sel_t  oeSel;
        logic [2:0]   foldPt;
        logic [2:0]   sumPtEn;
        logic         cascadeEn;
        logic         setEn;
        cmc_clr_sel_t clrSel;
        logic         clkEnEn;
        logic [1:0]   clkSel;
        logic         latchMode;
        cmc_dsel_t    dSel;
        cmc_xor_sel_t xorSel;
        logic         fbRegistered;
        logic         outRegistered;
    } cmc_config_t;

    // cell-level input group
    typedef struct packed {
        logic [GLOBAL_W-1:0]  globalBus;
        logic [REGION_W-1:0]  regionBus;
        logic                 cascadeIn;
        logic                 ioPin;
        logic [NUM_GCLK-1:0]  globalClock;
        logic                 globalClear;
        logic [1:0]           oePins;
        logic [OE_IO_W-1:0]   oeIoPins;
        logic [OE_CELL_W-1:0] oeCells;
    } cmc_cell_in_t;

endpackage

// ==== rtl/cmc_macrocell.sv ====
/*
  one configurable logic cell with its APB configuration port.
  assumes all cell inputs are pins or foreign logic, so each passes two
  flip-flops; clock, clear and latch behaviour are evaluated at the 40 MHz
  system clock, by edge detection on the synchronised selected clock.
*/
// Behaviour
// - five product terms over global and regional buses
// - all five terms may feed the sum
// - cascade input extends sum, up to forty
// - xor takes sum and term or fixed level
// - D, SR, toggle, JK via xor feedback
// - data from xor, term or pin
// - latch passes when clock high, holds low
// - clock from three global lines or term
// - flip-flop updates on selected rising edge
// - term clock enable low ignores global edges
// - clear: global, term, both or none
// - set: term or none
// - output and feedback each registered or combinatorial
// - output enable from pins, io or cells
// - input-only pin keeps internal logic usable
// - block input is forty global signals
// - inverted foldback term onto regional bus
// - signature, protect and status readable; terms and config locked by fuse
`timescale 1ns/1ps
`default_nettype none

module cmc_macrocell
    import cmc_pkg::*;
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [cmc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // cell inputs
    input  wire cmc_pkg::cmc_cell_in_t       cellIn,
    // cell outputs
    output logic                             cellOut,
    output logic                             cellOe,
    output logic                             feedback,
    output logic                             foldback,
    output logic                             cascadeOut
);
    import cmc_pkg::*;

    // configuration state
    logic [31:0]         ptTrue  [NUM_PT];
    logic [31:0]         ptComp  [NUM_PT];
    logic [PT_IN_W-32-1:0] ptTrueHi [NUM_PT];
    logic [PT_IN_W-32-1:0] ptCompHi [NUM_PT];
    cmc_config_t         cfg;
    logic [15:0]         signature;
    logic                fuse;

    // input synchronisers
    cmc_cell_in_t        syncA;
    cmc_cell_in_t        syncB;

    always_ff @(posedge clock) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= cellIn;
            syncB <= syncA;
        end
    end

    // product terms
    logic [PT_IN_W-1:0]  ptIn;
    logic [NUM_PT-1:0]   pt;

    assign ptIn = {syncB.regionBus, syncB.globalBus};

    always_comb begin
        for (int i = 0; i < NUM_PT; i++) begin
            pt[i] = &(~({ptTrueHi[i], ptTrue[i]} & ~ptIn)) &
                    &(~({ptCompHi[i], ptComp[i]} & ptIn));
        end
    end

    // product term allocator: terms 0..2 optionally added to the sum, always wired to control
    logic                orSum;
    logic                xorIn;
    logic                xorOut;
    logic                ctlPt;
    logic                state;

    always_comb begin
        orSum = pt[3] | pt[4];
        for (int i = 0; i < 3; i++) begin
            orSum = orSum | (pt[i] & cfg.sumPtEn[i]);
        end
        orSum = orSum | (syncB.cascadeIn & cfg.cascadeEn);
    end

    assign ctlPt = pt[0];

    always_comb begin
        unique case (cfg.xorSel)
            XOR_HIGH: xorIn = 1'b1;
            XOR_PT:   xorIn = pt[1] ^ state;
            default:  xorIn = 1'b0;
        endcase
    end

    assign xorOut = orSum ^ xorIn;

    // storage element
    logic                dIn;
    logic                selClk;
    logic                clkPrev;
    logic                clkRise;
    logic                clkEn;
    logic                clrAct;
    logic                setAct;

    always_comb begin
        unique case (cfg.dSel)
            D_PT:    dIn = pt[4];
            D_PIN:   dIn = syncB.ioPin;
            default: dIn = xorOut;
        endcase
    end

    always_comb begin
        if (cfg.clkSel == 2'd3) begin
            selClk = pt[2];
        end else begin
            selClk = syncB.globalClock[cfg.clkSel];
        end
    end

    assign clkEn   = !(cfg.clkEnEn && cfg.clkSel != 2'd3) || pt[3];
    assign clkRise = selClk && !clkPrev;

    always_comb begin
        unique case (cfg.clrSel)
            CLR_GLOBAL: clrAct = syncB.globalClear;
            CLR_PT:     clrAct = pt[0];
            CLR_BOTH:   clrAct = syncB.globalClear | pt[0];
            default:    clrAct = 1'b0;
        endcase
    end

    assign setAct = cfg.setEn & pt[1];

    always_ff @(posedge clock) begin
        if (rst) begin
            clkPrev <= 1'b0;
        end else begin
            clkPrev <= selClk;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= 1'b0;
        end else if (clrAct) begin
            state <= 1'b0;
        end else if (setAct) begin
            state <= 1'b1;
        end else if (cfg.latchMode) begin
            if (selClk && clkEn) begin
                state <= dIn;
            end
        end else if (clkRise && clkEn) begin
            state <= dIn;
        end
    end

    // outputs
    logic                oeRaw;

    always_comb begin
        unique case (cfg.oeSel)
            OE_PIN0: oeRaw = syncB.oePins[0];
            OE_PIN1: oeRaw = syncB.oePins[1];
            OE_IO:   oeRaw = syncB.oeIoPins[cfg.oeIoIdx];
            OE_CELL: oeRaw = syncB.oeCells[cfg.oeCellIdx];
            default: oeRaw = 1'b1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cellOut    <= 1'b0;
            cellOe     <= 1'b0;
            feedback   <= 1'b0;
            foldback   <= 1'b0;
            cascadeOut <= 1'b0;
        end else begin
            cellOut    <= cfg.outRegistered ? state : xorOut;
            cellOe     <= (cfg.oeSel == OE_ON) ? 1'b1 : (oeRaw ^ cfg.oeInvert);
            feedback   <= cfg.fbRegistered ? state : xorOut;
            foldback   <= ~pt[cfg.foldPt];
            cascadeOut <= orSum;
        end
    end

    // apb register file
    logic                setupAcc;
    logic                wrAcc;
    logic                ptHit;
    logic [2:0]          ptIdx;
    logic                ptHalf;
    logic                mapped;

    assign setupAcc = psel && !penable;
    assign wrAcc    = psel && penable && pwrite && pready;
    assign ptHit    = paddr <= ADDR_PT_LAST && paddr[1:0] == 2'b00 &&
                      paddr[ADDR_W-1:PT_WORD_SHIFT] < (ADDR_W-PT_WORD_SHIFT)'(NUM_PT);
    assign ptIdx    = paddr[PT_WORD_SHIFT+2:PT_WORD_SHIFT];
    assign ptHalf   = paddr[2];
    assign mapped   = (ptHit && ptIdx < 3'(NUM_PT)) || paddr == ADDR_CONFIG ||
                      paddr == ADDR_SIGN || paddr == ADDR_PROTECT ||
                      paddr == ADDR_STATUS;

    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setupAcc;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_PT; i++) begin
                ptTrue[i]   <= PT_MASK_OFF;
                ptComp[i]   <= PT_MASK_OFF;
                ptTrueHi[i] <= '1;
                ptCompHi[i] <= '1;
            end
            cfg       <= cmc_config_t'(CONFIG_RESET);
            signature <= SIGN_RESET;
            fuse      <= 1'b0;
        end else if (wrAcc && mapped) begin
            if (ptHit && ptIdx < 3'(NUM_PT) && !fuse) begin
                if (ptHalf) begin
                    ptComp[ptIdx]   <= pwdata;
                    ptCompHi[ptIdx] <= '0;
                end else begin
                    ptTrue[ptIdx]   <= pwdata;
                    ptTrueHi[ptIdx] <= '0;
                end
            end else if (paddr == ADDR_CONFIG && !fuse) begin
                cfg <= cmc_config_t'(pwdata);
            end else if (paddr == ADDR_SIGN) begin
                signature <= pwdata[15:0];
            end else if (paddr == ADDR_PROTECT && pwdata[0]) begin
                fuse <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setupAcc) begin
            pslverr <= !mapped;
            prdata  <= '0;
            if (!pwrite && mapped) begin
                if (paddr == ADDR_SIGN) begin
                    prdata <= {16'h0000, signature};
                end else if (paddr == ADDR_PROTECT) begin
                    prdata <= {31'h0000_0000, fuse};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {28'h000_0000, orSum, xorOut, cellOe, state};
                end else if (fuse) begin
                    prdata <= '0;
                end else if (paddr == ADDR_CONFIG) begin
                    prdata <= 32'(cfg);
                end else if (ptHalf) begin
                    prdata <= ptComp[ptIdx];
                end else begin
                    prdata <= ptTrue[ptIdx];
                end
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== testbench/cmc_chk.sv ====
/* checker for the logic cell ports.
   assumes a bind from tb_top and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cmc_chk
    import cmc_pkg::*;
(
    // watched ports
    input wire logic                         clock,
    input wire logic                         rst,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic [cmc_pkg::ADDR_W-1:0]   paddr,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire cmc_pkg::cmc_cell_in_t        cellIn,
    input wire logic                         cellOut,
    input wire logic                         cellOe,
    input wire logic                         feedback,
    input wire logic                         foldback,
    input wire logic                         cascadeOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0]   quiet;
    cmc_cell_in_t lastIn;
    // cycles with steady inputs and no bus traffic
    always_ff @(posedge clock) begin
        lastIn <= cellIn;
        if (rst || psel || cellIn != lastIn) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    sequence setup_s; psel && !penable; endsequence
    sequence sign_s; psel && !penable && paddr == ADDR_SIGN; endsequence
    sequence far_s; psel && !penable && paddr > ADDR_STATUS; endsequence
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without ready or with data");
    sign_open_a: assert property (sign_s |=> pready && !pslverr)
        else $error("signature refused");
    unmapped_err_a: assert property (far_s |=> pslverr)
        else $error("unmapped address accepted");
    reset_clear_a: assert property ($fell(rst) |-> !cellOut && !cellOe && !feedback
        && !foldback && !cascadeOut) else $error("outputs not cleared by reset");
    quiet_hold_a: assert property (quiet >= 4'h8 |-> $stable(cellOut) && $stable(feedback)
        && $stable(cascadeOut)) else $error("state moved without a clock edge");
endmodule
`default_nettype wire

// ==== testbench/cmc_nbr_model.sv ====
/* neighbour cells: cascade sum and regional foldback terms.
   assumes the bench asks for the neighbour sum level. */
`timescale 1ns/1ps
`default_nettype none
module cmc_nbr_model
    import cmc_pkg::*;
(
    // clock and request
    input wire logic                           clock,
    input wire logic                           sumReq,
    // cell side
    input wire logic                           foldback,
    output logic                               cascadeIn,
    output logic [cmc_pkg::REGION_W-1:0]       regionBus
);
    always_ff @(posedge clock) begin
        cascadeIn <= sumReq;
        regionBus <= {3'h7, foldback};
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* self-checking bench for the logic cell.
   assumes the cell answers apb and settles within six clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cmc_pkg::*;
    logic         clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000, prdata, r;
    logic         pready, pslverr, cellOut, cellOe, feedback, foldback, cascadeOut;
    logic         sumReq = 1'b0, cascIn, e, st, d, en, s, x, c;
    logic [3:0]   region;
    logic [15:0]  sig;
    cmc_cell_in_t cin = '0, cellIn;
    cmc_config_t  cfg;
    int           fail_count = 0, n_compared = 0, cyc = 0;
    always #12.5 clock = ~clock;
    always_comb begin
        cellIn = cin;
        cellIn.regionBus = region;
        cellIn.cascadeIn = cascIn;
    end
    cmc_macrocell dut(.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cellIn, .cellOut, .cellOe, .feedback, .foldback, .cascadeOut);
    cmc_nbr_model nbr(.clock, .sumReq, .foldback, .cascadeIn(cascIn), .regionBus(region));
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            wrap_up;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task chk1(input logic got, input logic exp, input string m);
        chk({31'h0, got}, {31'h0, exp}, m);
    endtask
    task settle;
        repeat (6) @(posedge clock);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dv;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    initial begin
        void'($urandom(69346));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        chk(r, CONFIG_RESET, "config reset");
        sig = 16'($urandom);
        apb(1'b1, ADDR_SIGN, {16'h0000, sig});
        apb(1'b0, ADDR_SIGN, 32'h0000_0000);
        chk(r, {16'h0000, sig}, "signature");
        apb(1'b0, 8'h60, 32'h0000_0000);
        chk({r[30:0], e}, 32'h0000_0001, "unmapped");
        $display("test registers done");
        // term n follows global bit n
        for (int n = 0; n < 5; n++) begin
            apb(1'b1, 8'(8 * n), 32'h0000_0001 << n);
            apb(1'b1, 8'(8 * n + 4), 32'h0000_0000);
        end
        cin.globalClear <= 1'b1;
        cfg = '0;
        cfg.clrSel = CLR_GLOBAL;
        repeat (24) begin
            cfg.xorSel = cmc_xor_sel_t'($urandom % 3);
            cfg.sumPtEn = 3'($urandom);
            if (cfg.xorSel == XOR_PT) cfg.sumPtEn[1] = 1'b0;
            cfg.cascadeEn = 1'($urandom);
            cfg.foldPt = 3'($urandom % 5);
            cfg.oeSel = ($urandom % 3 == 2) ? OE_ON : cmc_oe_sel_t'($urandom % 2);
            cfg.oeInvert = (cfg.oeSel != OE_ON) & 1'($urandom);
            apb(1'b1, ADDR_CONFIG, cfg);
            cin.globalBus <= 40'({$urandom, $urandom});
            cin.oePins <= 2'($urandom);
            sumReq <= 1'($urandom);
            settle;
            s = |(cin.globalBus[4:0] & {2'h3, cfg.sumPtEn}) | (cfg.cascadeEn & sumReq);
            x = s ^ (cfg.xorSel == XOR_HIGH) ^ (cfg.xorSel == XOR_PT && cin.globalBus[1]);
            chk1(cellOut, x, "comb out");
            chk1(feedback, x, "comb feedback");
            chk1(cascadeOut, s, "cascade out");
            chk1(foldback, ~cin.globalBus[cfg.foldPt], "foldback");
            c = (cfg.oeSel == OE_ON) | (cin.oePins[cfg.oeSel[0]] ^ cfg.oeInvert);
            chk1(cellOe, c, "enable");
        end
        $display("test comb done");
        cin.globalClear <= 1'b0;
        cfg = '0;
        cfg.outRegistered = 1'b1;
        cfg.fbRegistered = 1'b1;
        cfg.dSel = D_PT;
        cfg.clkEnEn = 1'b1;
        st = 1'b0;
        for (int k = 0; k < 16; k++) begin
            cfg.clkSel = 2'(k % 4);
            apb(1'b1, ADDR_CONFIG, cfg);
            d = 1'($urandom);
            en = 1'($urandom);
            cin.globalBus <= {35'h0, d, en, 3'h0};
            settle;
            chk1(cellOut, st, "moved without edge");
            if (k % 4 == 3) cin.globalBus[2] <= 1'b1;
            else cin.globalClock[k % 4] <= 1'b1;
            settle;
            if (en || k % 4 == 3) st = d;
            chk1(cellOut, st, "clocked");
            chk1(feedback, st, "reg feedback");
            cin.globalClock <= 3'h0;
            cin.globalBus[2] <= 1'b0;
        end
        cfg.dSel = D_XOR;
        cfg.xorSel = XOR_PT;
        cfg.clkSel = 2'h0;
        cfg.clkEnEn = 1'b0;
        apb(1'b1, ADDR_CONFIG, cfg);
        cin.globalBus <= 40'h00_0000_0002;
        settle;
        repeat (3) begin
            cin.globalClock[0] <= 1'b1;
            settle;
            st = ~st;
            chk1(cellOut, st, "toggle");
            cin.globalClock[0] <= 1'b0;
            settle;
        end
        $display("test flip-flop done");
        cfg.dSel = D_PT;
        cfg.latchMode = 1'b1;
        apb(1'b1, ADDR_CONFIG, cfg);
        cin.globalClock[0] <= 1'b1;
        repeat (3) begin
            st = 1'($urandom);
            cin.globalBus <= {35'h0, st, 4'h0};
            settle;
            chk1(cellOut, st, "latch open");
        end
        cin.globalClock[0] <= 1'b0;
        settle;
        cin.globalBus <= {35'h0, ~st, 4'h0};
        settle;
        chk1(cellOut, st, "latch hold");
        $display("test latch done");
        cfg.latchMode = 1'b0;
        for (int k = 0; k < 16; k++) begin
            cfg.clrSel = cmc_clr_sel_t'(k % 4);
            cfg.setEn = 1'($urandom);
            apb(1'b1, ADDR_CONFIG, cfg);
            cin.globalBus <= 40'($urandom % 4);
            cin.globalClear <= 1'($urandom);
            settle;
            c = (cfg.clrSel[0] & cin.globalClear) | (cfg.clrSel[1] & cin.globalBus[0]);
            if (c) st = 1'b0;
            else if (cfg.setEn && cin.globalBus[1]) st = 1'b1;
            chk1(cellOut, st, "clear and set");
            cin.globalBus <= 40'h00_0000_0000;
            cin.globalClear <= 1'b0;
            settle;
        end
        $display("test clear done");
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        chk(r, cfg, "config readback");
        apb(1'b1, ADDR_PROTECT, 32'h0000_0001);
        apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        chk(r, 32'h0000_0000, "locked config");
        apb(1'b0, ADDR_PT_BASE, 32'h0000_0000);
        chk(r, 32'h0000_0000, "locked term");
        apb(1'b0, ADDR_SIGN, 32'h0000_0000);
        chk(r, {16'h0000, sig}, "signature after lock");
        $display("test lock done");
        wrap_up;
    end
endmodule
bind cmc_macrocell cmc_chk chk(.clock, .rst, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .cellIn, .cellOut, .cellOe, .feedback, .foldback, .cascadeOut);
`default_nettype wire
